// ==== design/dcache_pkg.sv ====
package dcache_pkg;

  // geometry: direct mapped, 16-byte lines of four long words
  localparam int LINES = 8;
  localparam int IDX_W = 3;
  localparam int TAG_W = 25;
  localparam int IDX_LSB = 4;
  localparam int TAG_LSB = 7;
  localparam int WORD_LSB = 2;
  localparam int HALF_BIT = 3;
  localparam logic [3:0] HALF_BYTES = 4'h8;

  // snoop control codes
  localparam logic [1:0] SC_INHIBIT = 2'h0;
  localparam logic [1:0] SC_SINK = 2'h1;
  localparam logic [1:0] SC_INVAL = 2'h2;
  localparam logic [1:0] SC_RESERVED = 2'h3;

  // transfer size codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  localparam logic [1:0] LAST_WORD = 2'h3;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_SNP_XFER = 2'h1,
    S_CPU2 = 2'h3
  } state_t;

endpackage

// ==== design/dcache_lines.sv ====
`timescale 1ns/1ns
module dcache_lines
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // lookup
  input wire logic [dcache_pkg::IDX_W-1:0] rd_index,
  output logic [dcache_pkg::TAG_W-1:0] rd_tag,
  output logic rd_valid,
  output logic [3:0] rd_dirty,
  output logic [127:0] rd_line,
  // line load
  input wire logic load_en,
  input wire logic [31:0] load_addr,
  input wire logic [127:0] load_data,
  // invalidate
  input wire logic inval_en,
  input wire logic [dcache_pkg::IDX_W-1:0] inval_index,
  // long word write
  input wire logic wr_en,
  input wire logic [dcache_pkg::IDX_W-1:0] wr_index,
  input wire logic [1:0] wr_word,
  input wire logic [3:0] wr_be,
  input wire logic [31:0] wr_data,
  input wire logic wr_set_dirty
);

  typedef struct packed {
    logic [dcache_pkg::LINES-1:0][dcache_pkg::TAG_W-1:0] tag;
    logic [dcache_pkg::LINES-1:0] valid;
    logic [dcache_pkg::LINES-1:0][3:0] dirty;
    logic [dcache_pkg::LINES-1:0][3:0][31:0] data;
  } lines_t;

  lines_t r;
  lines_t r_nxt;

  assign rd_tag = r.tag[rd_index];
  assign rd_valid = r.valid[rd_index];
  assign rd_dirty = r.dirty[rd_index];
  assign rd_line = r.data[rd_index];

  always_comb
  begin
    r_nxt = r;
    if (load_en)
    begin
      r_nxt.tag[load_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB]] = load_addr[31:dcache_pkg::TAG_LSB];
      r_nxt.valid[load_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB]] = 1'b1;
      r_nxt.dirty[load_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB]] = 4'h0;
      r_nxt.data[load_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB]] = load_data;
    end
    if (wr_en)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_be[b])
        begin
          r_nxt.data[wr_index][wr_word][b*8 +: 8] = wr_data[b*8 +: 8];
        end
      end
      if (wr_set_dirty)
      begin
        r_nxt.dirty[wr_index][wr_word] = 1'b1;
      end
    end
    // dirty data is dropped with the line
    if (inval_en)
    begin
      r_nxt.valid[inval_index] = 1'b0;
      r_nxt.dirty[inval_index] = 4'h0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

endmodule

// ==== design/dcache_hit_snoop.sv ====
// Summary of operation
// - processor read hit starts no bus write and keeps the line state.
// - address bit 3 selects the half-line driven onto the read data.
// - read hit inside a half-line takes one access, a crossing one takes two; writes take one.
// - snooped read hitting a clean line does not inhibit; memory answers, and mark-invalid drops the line.
// - snooped read hitting a dirty line inhibits memory and supplies the data.
// - snooped read keeps line state unless mark-invalid, then a dirty line is invalidated after its transfer and a clean one at once.
// - writethrough write hit updates long words and requests an external write.
// - copyback write hit updates the line and sets dirty bits, no bus write.
// - snooped line write hitting a valid line invalidates it.
// - snooped small write on dirty hit with sink code is sunk and marked dirty.
// - snooped write with the invalidate code invalidates the hit line.
// - snoops act even while the cache is disabled for processor accesses.
// - snoop wins the arrays over the processor.
// - codes 00 and 11 inhibit snooping for reads and writes.
// - code 01 supplies dirty data keeping it dirty, and sinks small writes.
// - code 10 supplies dirty data then invalidates, and invalidates on writes.
// - no instruction cache watches processor data writes.
// - only transfers marked snoopable may change a line state.
// - snoops that miss leave contents and states untouched.
`timescale 1ns/1ns
module dcache_hit_snoop
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // processor side
  input wire logic cache_enable,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_copyback,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_addr,
  input wire logic [3:0] cpu_be,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_stall,
  output logic cpu_beat,
  output logic [63:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_miss,
  // external write request for writethrough hits
  output logic ext_wr_req,
  output logic [31:0] ext_wr_addr,
  output logic [31:0] ext_wr_data,
  output logic [3:0] ext_wr_be,
  // snooped bus transfers
  input wire logic snp_valid,
  input wire logic snp_snoopable,
  input wire logic snp_we,
  input wire logic snoop_code_hi,
  input wire logic snoop_code_lo,
  input wire logic [1:0] snp_size,
  input wire logic [31:0] snp_addr,
  input wire logic [3:0] snp_be,
  input wire logic [31:0] snp_wdata,
  output logic snp_inhibit,
  output logic snp_rvalid,
  output logic [31:0] snp_rdata,
  output logic snp_done,
  // line load from the fill path
  input wire logic load_en,
  input wire logic [31:0] load_addr,
  input wire logic [127:0] load_data
);

  typedef struct packed {
    dcache_pkg::state_t st;
    logic [63:0] cpu_rdata;
    logic cpu_beat;
    logic cpu_ack;
    logic cpu_miss;
    logic [31:0] cpu2_addr;
    logic ext_wr;
    logic [31:0] ext_addr;
    logic [31:0] ext_data;
    logic [3:0] ext_be;
    logic snp_inhibit;
    logic snp_rvalid;
    logic [31:0] snp_rdata;
    logic snp_done;
    logic [1:0] snp_left;
    logic [1:0] snp_word;
    logic [dcache_pkg::IDX_W-1:0] snp_index;
    logic snp_mark_inv;
    logic back_cpu2;
  } state_vec_t;

  state_vec_t r;
  state_vec_t r_nxt;

  logic [1:0] snoop_code, wr_word;
  logic snp_take, cpu_take, rd_valid, lk_hit, lk_dirty, cpu_cross, inval_en, wr_en, wr_set_dirty;
  logic [31:0] lk_addr, wr_data;
  logic [dcache_pkg::IDX_W-1:0] rd_index, wr_index;
  logic [dcache_pkg::TAG_W-1:0] rd_tag;
  logic [3:0] rd_dirty, cpu_end, wr_be;
  logic [127:0] rd_line;

  assign snoop_code = {snoop_code_hi, snoop_code_lo};
  // codes 00 and 11 are ignored, as are unmarked transfers; cache_enable plays no part here
  assign snp_take = snp_valid && snp_snoopable && (r.st != dcache_pkg::S_SNP_XFER) &&
    (snoop_code == dcache_pkg::SC_SINK || snoop_code == dcache_pkg::SC_INVAL);
  assign cpu_take = cpu_req && !snp_take && (r.st == dcache_pkg::S_IDLE) && !r.cpu_ack;
  assign cpu_stall = cpu_req && (snp_take || r.st == dcache_pkg::S_SNP_XFER);

  assign lk_addr = snp_take ? snp_addr :
    (r.st == dcache_pkg::S_CPU2) ? r.cpu2_addr : cpu_addr;

  assign rd_index = (r.st == dcache_pkg::S_SNP_XFER) ? r.snp_index :
    lk_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB];
  assign lk_hit = rd_valid && (rd_tag == lk_addr[31:dcache_pkg::TAG_LSB]);
  assign lk_dirty = lk_hit && (|rd_dirty);
  assign cpu_end = {1'b0, cpu_addr[2:0]} + ((cpu_size == dcache_pkg::SZ_BYTE) ? 4'h1 :
    (cpu_size == dcache_pkg::SZ_WORD) ? 4'h2 : 4'h4);
  assign cpu_cross = cpu_end > dcache_pkg::HALF_BYTES;

  always_comb
  begin
    r_nxt = r;
    r_nxt.cpu_beat = 1'b0;
    r_nxt.cpu_ack = 1'b0;
    r_nxt.cpu_miss = 1'b0;
    r_nxt.ext_wr = 1'b0;
    r_nxt.snp_inhibit = 1'b0;
    r_nxt.snp_rvalid = 1'b0;
    r_nxt.snp_done = 1'b0;
    inval_en = 1'b0;
    wr_en = 1'b0;
    wr_index = lk_addr[dcache_pkg::TAG_LSB-1:dcache_pkg::IDX_LSB];
    wr_word = lk_addr[dcache_pkg::IDX_LSB-1:dcache_pkg::WORD_LSB];
    wr_be = cpu_be;
    wr_data = cpu_wdata;
    wr_set_dirty = 1'b0;
    case (r.st)
      dcache_pkg::S_IDLE, dcache_pkg::S_CPU2:
      begin
        if (snp_take)
        begin
          r_nxt.back_cpu2 = (r.st == dcache_pkg::S_CPU2);
          if (!snp_we)
          begin
            if (lk_dirty)
            begin
              r_nxt.st = dcache_pkg::S_SNP_XFER;
              r_nxt.snp_inhibit = 1'b1;
              r_nxt.snp_rvalid = 1'b1;
              r_nxt.snp_rdata = rd_line[32*lk_addr[3:2] +: 32];
              r_nxt.snp_word = lk_addr[3:2] + 2'h1;
              r_nxt.snp_left = (snp_size == dcache_pkg::SZ_LINE) ? dcache_pkg::LAST_WORD : 2'h0;
              r_nxt.snp_index = rd_index;
              r_nxt.snp_mark_inv = (snoop_code == dcache_pkg::SC_INVAL);
            end
            else
            begin
              // clean hit lets memory answer; mark-invalid still drops it
              r_nxt.snp_done = 1'b1;
              inval_en = lk_hit && (snoop_code == dcache_pkg::SC_INVAL);
            end
          end
          else
          begin
            r_nxt.snp_done = 1'b1;
            if (lk_hit && (snp_size == dcache_pkg::SZ_LINE || snoop_code == dcache_pkg::SC_INVAL))
            begin
              inval_en = 1'b1;
            end
            else if (lk_dirty && snoop_code == dcache_pkg::SC_SINK)
            begin
              r_nxt.snp_inhibit = 1'b1;
              wr_en = 1'b1;
              wr_be = snp_be;
              wr_data = snp_wdata;
              wr_set_dirty = 1'b1;
            end
          end
        end
        else if (r.st == dcache_pkg::S_CPU2)
        begin
          // second half-line of a crossing operand
          r_nxt.st = dcache_pkg::S_IDLE;
          r_nxt.cpu_ack = 1'b1;
          r_nxt.cpu_beat = lk_hit;
          r_nxt.cpu_miss = !lk_hit;
          r_nxt.cpu_rdata = lk_hit ? rd_line[64*lk_addr[dcache_pkg::HALF_BIT] +: 64] : r.cpu_rdata;
        end
        else if (cpu_take)
        begin
          if (!cache_enable || !lk_hit)
          begin
            r_nxt.cpu_ack = 1'b1;
            r_nxt.cpu_miss = 1'b1;
          end
          else if (!cpu_we)
          begin
            r_nxt.cpu_beat = 1'b1;
            r_nxt.cpu_rdata = rd_line[64*lk_addr[dcache_pkg::HALF_BIT] +: 64];
            if (cpu_cross)
            begin
              r_nxt.st = dcache_pkg::S_CPU2;
              r_nxt.cpu2_addr = {cpu_addr[31:dcache_pkg::HALF_BIT], 3'h0} + 32'h8;
            end
            else
            begin
              r_nxt.cpu_ack = 1'b1;
            end
          end
          else
          begin
            // only the data cache sees this write
            r_nxt.cpu_ack = 1'b1;
            wr_en = 1'b1;
            wr_set_dirty = cpu_copyback;
            r_nxt.ext_wr = !cpu_copyback;
            r_nxt.ext_addr = cpu_addr;
            r_nxt.ext_data = cpu_wdata;
            r_nxt.ext_be = cpu_be;
          end
        end
      end
      dcache_pkg::S_SNP_XFER:
      begin
        if (r.snp_left == 2'h0)
        begin
          r_nxt.snp_done = 1'b1;
          r_nxt.st = r.back_cpu2 ? dcache_pkg::S_CPU2 : dcache_pkg::S_IDLE;
          inval_en = r.snp_mark_inv;
        end
        else
        begin
          r_nxt.snp_inhibit = 1'b1;
          r_nxt.snp_rvalid = 1'b1;
          r_nxt.snp_rdata = rd_line[32*r.snp_word +: 32];
          r_nxt.snp_word = r.snp_word + 2'h1;
          r_nxt.snp_left = r.snp_left - 2'h1;
        end
      end
      default:
      begin
        r_nxt.st = dcache_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  dcache_lines u_lines
  (
    .clk(clk), .reset(reset), .rd_index(rd_index), .rd_tag(rd_tag), .rd_valid(rd_valid),
    .rd_dirty(rd_dirty), .rd_line(rd_line), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .inval_en(inval_en), .inval_index(rd_index), .wr_en(wr_en),
    .wr_index(wr_index), .wr_word(wr_word), .wr_be(wr_be), .wr_data(wr_data),
    .wr_set_dirty(wr_set_dirty)
  );

  assign cpu_beat = r.cpu_beat;
  assign cpu_rdata = r.cpu_rdata;
  assign cpu_ack = r.cpu_ack;
  assign cpu_miss = r.cpu_miss;
  assign ext_wr_req = r.ext_wr;
  assign ext_wr_addr = r.ext_addr;
  assign ext_wr_data = r.ext_data;
  assign ext_wr_be = r.ext_be;
  assign snp_inhibit = r.snp_inhibit;
  assign snp_rvalid = r.snp_rvalid;
  assign snp_rdata = r.snp_rdata;
  assign snp_done = r.snp_done;

  property p_rd_hit_quiet;
    @(posedge clk) disable iff (reset)
    (cpu_take && cache_enable && lk_hit && !cpu_we) |=> !ext_wr_req && cpu_beat;
  endproperty
  a_rd_hit_quiet: assert property (p_rd_hit_quiet) else $error("read hit disturbed the bus");
  property p_half_sel;
    @(posedge clk) disable iff (reset)
    (cpu_take && cache_enable && lk_hit && !cpu_we)
      |=> cpu_rdata == $past(rd_line[64*cpu_addr[3] +: 64]);
  endproperty
  a_half_sel: assert property (p_half_sel) else $error("wrong half-line driven");
  property p_two_access;
    @(posedge clk) disable iff (reset)
    (cpu_take && cache_enable && lk_hit && !cpu_we && cpu_cross) |=> !cpu_ack ##[1:40] cpu_ack;
  endproperty
  a_two_access: assert property (p_two_access) else $error("crossing read not done in two accesses");
  property p_clean_read;
    @(posedge clk) disable iff (reset)
    (snp_take && !snp_we && !lk_dirty) |=> !snp_inhibit && snp_done;
  endproperty
  a_clean_read: assert property (p_clean_read) else $error("clean snoop read inhibited memory");
  property p_dirty_read;
    @(posedge clk) disable iff (reset)
    (snp_take && !snp_we && lk_dirty && snp_size == dcache_pkg::SZ_LINE)
      |=> (snp_inhibit && snp_rvalid) [*4] ##1 snp_done;
  endproperty
  a_dirty_read: assert property (p_dirty_read) else $error("dirty line not supplied");
  property p_wt_write;
    @(posedge clk) disable iff (reset)
    (cpu_take && cache_enable && lk_hit && cpu_we) |=> ext_wr_req == !$past(cpu_copyback);
  endproperty
  a_wt_write: assert property (p_wt_write) else $error("write hit bus request wrong");
  property p_snoop_first;
    @(posedge clk) disable iff (reset)
    (snp_take && cpu_req) |-> cpu_stall ##1 !cpu_ack && !cpu_beat;
  endproperty
  a_snoop_first: assert property (p_snoop_first) else $error("processor took arrays from snoop");
  property p_miss_quiet;
    @(posedge clk) disable iff (reset)
    (snp_take && !lk_hit) |-> !inval_en && !wr_en ##1 !snp_inhibit;
  endproperty
  a_miss_quiet: assert property (p_miss_quiet) else $error("snoop miss changed the cache");
  property p_inhibit_codes;
    @(posedge clk) disable iff (reset)
    (snp_valid && r.st != dcache_pkg::S_SNP_XFER &&
      (snoop_code == dcache_pkg::SC_INHIBIT || snoop_code == dcache_pkg::SC_RESERVED || !snp_snoopable))
      |-> !inval_en ##1 !snp_done && !snp_inhibit;
  endproperty
  a_inhibit_codes: assert property (p_inhibit_codes) else $error("inhibited snoop acted on");

endmodule

// ==== verification/alt_master.sv ====
`timescale 1ns/1ns
module alt_master
(
  // clock
  input wire logic clk,
  // snooped transfer
  output logic snp_valid,
  output logic snp_snoopable,
  output logic snp_we,
  output logic snoop_code_hi,
  output logic snoop_code_lo,
  output logic [1:0] snp_size,
  output logic [31:0] snp_addr,
  output logic [3:0] snp_be,
  output logic [31:0] snp_wdata,
  // device answer
  input wire logic snp_inhibit,
  input wire logic snp_rvalid,
  input wire logic [31:0] snp_rdata,
  input wire logic snp_done
);
  initial
  begin
    snp_valid = 1'b0;
    snp_snoopable = 1'b0;
    snp_we = 1'b0;
    {snoop_code_hi, snoop_code_lo} = 2'h0;
    snp_size = 2'h0;
    snp_addr = 32'h0;
    snp_be = 4'hf;
    snp_wdata = 32'h0;
  end

  // one transfer; read words collect with the first one lowest
  task automatic snoop(input logic we, input logic mk, input logic [1:0] code, input logic [1:0] sz,
    input logic [31:0] a, input logic [31:0] wd, output logic dn, output int ninh, output logic [127:0] w);
    int i;
    dn = 1'b0;
    ninh = 0;
    w = 128'h0;
    @(posedge clk);
    snp_valid <= 1'b1;
    snp_snoopable <= mk;
    snp_we <= we;
    {snoop_code_hi, snoop_code_lo} <= code;
    snp_size <= sz;
    snp_addr <= a;
    snp_wdata <= wd;
    @(posedge clk);
    snp_valid <= 1'b0;
    // released lines change rather than hold the last value
    snp_addr <= ~a;
    snp_wdata <= ~wd;
    for (i = 0; i < 8 && dn !== 1'b1; i++)
    begin
      @(posedge clk);
      if (snp_inhibit === 1'b1)
        ninh++;
      if (snp_rvalid === 1'b1)
        w = {snp_rdata, w[127:32]};
      dn = snp_done;
    end
  endtask
endmodule

// ==== verification/test_dcache_hit_snoop.sv ====
`timescale 1ns/1ns
module test_dcache_hit_snoop;
  logic clk, reset, cache_enable, cpu_req, cpu_we, cpu_copyback, load_en;
  logic [1:0] cpu_size, snp_size;
  logic [31:0] cpu_addr, cpu_wdata, load_addr, ext_wr_addr, ext_wr_data, snp_addr, snp_wdata, snp_rdata;
  logic [3:0] cpu_be, ext_wr_be, snp_be;
  logic [63:0] cpu_rdata;
  logic [127:0] load_data, sw, hb;
  logic cpu_stall, cpu_beat, cpu_ack, cpu_miss, ext_wr_req, snp_valid, snp_snoopable, snp_we;
  logic snoop_code_hi, snoop_code_lo, snp_inhibit, snp_rvalid, snp_done, miss, ext, sdn, stall;
  logic [1:0] cd [4];
  int n_fail, num_checks, nbeat, ninh;
  localparam logic [127:0] D = 128'ha3a3a3a3_a2a2a2a2_a1a1a1a1_a0a0a0a0;

  dcache_hit_snoop uut
  (
    .clk, .reset, .cache_enable, .cpu_req, .cpu_we, .cpu_copyback, .cpu_size, .cpu_addr, .cpu_be,
    .cpu_wdata, .cpu_stall, .cpu_beat, .cpu_rdata, .cpu_ack, .cpu_miss, .ext_wr_req, .ext_wr_addr,
    .ext_wr_data, .ext_wr_be, .snp_valid, .snp_snoopable, .snp_we, .snoop_code_hi, .snoop_code_lo,
    .snp_size, .snp_addr, .snp_be, .snp_wdata, .snp_inhibit, .snp_rvalid, .snp_rdata, .snp_done,
    .load_en, .load_addr, .load_data
  );

  alt_master alt
  (
    .clk, .snp_valid, .snp_snoopable, .snp_we, .snoop_code_hi, .snoop_code_lo, .snp_size,
    .snp_addr, .snp_be, .snp_wdata, .snp_inhibit, .snp_rvalid, .snp_rdata, .snp_done
  );

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [255:0] e, input logic [255:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic load(input logic [31:0] a);
    @(posedge clk);
    load_en <= 1'b1;
    load_addr <= a;
    load_data <= D;
    @(posedge clk);
    load_en <= 1'b0;
  endtask

  // beats collect in hb, second beat highest
  task automatic cpu(input logic we, input logic cb, input logic [31:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_copyback <= cb;
    cpu_addr <= a;
    cpu_wdata <= wd;
    nbeat = 0;
    ext = 1'b0;
    for (i = 0; i < 20 && cpu_ack !== 1'b1; i++)
    begin
      @(posedge clk);
      if (cpu_beat === 1'b1)
      begin
        hb = {cpu_rdata, hb[127:64]};
        nbeat++;
      end
      if (ext_wr_req === 1'b1)
        ext = 1'b1;
    end
    cpu_req <= 1'b0;
    miss = cpu_miss;
    if (cpu_ack !== 1'b1)
    begin
      n_fail++;
      print_verdict();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    n_fail = 0;
    num_checks = 0;
    reset = 1'b1;
    cache_enable = 1'b1;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_copyback = 1'b0;
    cpu_size = 2'h0;
    cpu_addr = 32'h0;
    cpu_be = 4'hf;
    cpu_wdata = 32'h0;
    load_en = 1'b0;
    load_addr = 32'h0;
    load_data = 128'h0;
    hb = 128'h0;
    cd = '{2'h0, 2'h3, 2'h2, 2'h2};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    load(32'h10);
    cpu(0, 0, 32'h18, 0);
    check("rd_hit", {D[127:64], 32'h1, 2'b00}, {hb[127:64], nbeat, miss, ext});
    cpu(0, 0, 32'h16, 0);
    check("rd_cross", {D, 32'h2, 1'b0}, {hb, nbeat, miss});
    cpu_size <= dcache_pkg::SZ_WORD;
    cpu(0, 0, 32'h16, 0);
    check("rd_word", {D[63:0], 32'h1, 1'b0}, {hb[127:64], nbeat, miss});
    cpu_size <= dcache_pkg::SZ_LONG;
    cpu(1, 0, 32'h14, 32'h12345678);
    check("wthru", {2'b01, 32'h12345678, 32'h14, 4'hf}, {miss, ext, ext_wr_data, ext_wr_addr, ext_wr_be});
    cpu(0, 0, 32'h10, 0);
    check("wthru_rd", {32'h12345678, D[31:0]}, hb[127:64]);
    alt.snoop(0, 1, 2'h1, 2'h0, 32'h14, 0, sdn, ninh, sw);
    check("snp_clean", {1'b1, 32'h0}, {sdn, ninh});
    cpu(1, 1, 32'h18, 32'hcafe0001);
    check("cback", 2'b00, {miss, ext});
    repeat (2)
    begin
      alt.snoop(0, 1, 2'h1, 2'h0, 32'h18, 0, sdn, ninh, sw);
      check("snp_dirty", {1'b1, 32'h1, 32'hcafe0001}, {sdn, ninh, sw[127:96]});
    end
    alt.snoop(1, 1, 2'h1, 2'h0, 32'h18, 32'h5a5a0002, sdn, ninh, sw);
    check("sink", {1'b1, 32'h1}, {sdn, ninh});
    cpu(0, 0, 32'h18, 0);
    check("sink_rd", {D[127:96], 32'h5a5a0002}, hb[127:64]);
    // ignored codes, unmarked transfer, then a miss on the same index
    for (int k = 0; k < 4; k++)
    begin
      alt.snoop(1, k != 2, cd[k], 2'h3, k == 3 ? 32'h118 : 32'h18, 0, sdn, ninh, sw);
      check("no_snp", k == 3, sdn);
    end
    cpu(0, 0, 32'h18, 0);
    check("kept", {1'b0, D[127:96], 32'h5a5a0002}, {miss, hb[127:64]});
    fork
      alt.snoop(0, 1, 2'h2, 2'h3, 32'h18, 0, sdn, ninh, sw);
      cpu(0, 0, 32'h0, 0);
      begin
        repeat (3) @(posedge clk);
        stall = cpu_stall;
      end
    join
    check("snp_line", {1'b1, 32'h4, 32'h12345678, D[31:0], D[127:96], 32'h5a5a0002, 1'b1},
      {sdn, ninh, sw, stall});
    cpu(0, 0, 32'h18, 0);
    check("rd_inval", 1'b1, miss);
    load(32'h20);
    cache_enable <= 1'b0;
    cpu(0, 0, 32'h20, 0);
    check("disabled", 1'b1, miss);
    alt.snoop(1, 1, 2'h1, 2'h3, 32'h20, 0, sdn, ninh, sw);
    cache_enable <= 1'b1;
    cpu(0, 0, 32'h20, 0);
    check("line_wr", 2'b11, {sdn, miss});
    load(32'h30);
    alt.snoop(1, 1, 2'h2, 2'h0, 32'h30, 0, sdn, ninh, sw);
    cpu(0, 0, 32'h30, 0);
    check("inv_wr", 2'b11, {sdn, miss});
    print_verdict();
  end
endmodule
